/* src/lcdc_cfg.svh */
// Constants of the segment display configuration and memory block
`ifndef LCDC_CFG_SVH
`define LCDC_CFG_SVH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define LCDC_ADDR_CONFIG     8'h95
`define LCDC_ADDR_CLOCK      8'h96
`define LCDC_ADDR_SEG_EN_A   8'h97
`define LCDC_ADDR_POINTER    8'hac
`define LCDC_ADDR_DATA       8'hae
`define LCDC_ADDR_SEG_EN_B   8'hed

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LCDC_CFG_CLEAR_BIT   6
`define LCDC_CFG_CLKSEL_BIT  3
`define LCDC_CFG_BIAS_BIT    2
`define LCDC_CFG_MUX_MSB     1
`define LCDC_CFG_MUX_LSB     0
`define LCDC_CLK_FD_MSB      3
`define LCDC_CLK_FD_LSB      0
`define LCDC_SEGA_MSB        7
`define LCDC_SEGA_LSB        2
`define LCDC_SEGB_MSB        3
`define LCDC_SEGB_LSB        0
`define LCDC_PTR_DIR_BIT     7
`define LCDC_PTR_SCR_MSB     5
`define LCDC_PTR_SCR_LSB     4
`define LCDC_PTR_ADR_MSB     3
`define LCDC_PTR_ADR_LSB     0

// ---------------------------------------------------------------
// Reset values and memory shape
// ---------------------------------------------------------------
`define LCDC_RST_BYTE        8'h00
`define LCDC_RST_SEGA        6'h00
`define LCDC_RST_SEGB        4'h0
`define LCDC_RST_FD          4'h0
`define LCDC_LAST_BYTE       4'he
`define LCDC_FIXED_SEGS      16'hffff

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LCDC_SYS_CLK_HZ      40000000
`define LCDC_SRC_CLK_HZ      128
`define LCDC_PRESCALE        (`LCDC_SYS_CLK_HZ / `LCDC_SRC_CLK_HZ)
`define LCDC_DIV_1           4'h1
`define LCDC_DIV_2           4'h2
`define LCDC_DIV_4           4'h4
`define LCDC_DIV_6           4'h6
`define LCDC_DIV_8           4'h8
`define LCDC_FD_FASTEST      4'hf
`define LCDC_FD_DEFAULT      4'h0
`define LCDC_FD_SECOND       4'h2
`define LCDC_FD_FIRST        4'h1

`endif

/* src/lcdc_pkg.sv */
// Types of the segment display configuration and memory block
package lcdc_pkg;

    typedef enum logic [1:0] {
        LCDC_MUX_2A = 2'h0,
        LCDC_MUX_2B = 2'h1,
        LCDC_MUX_3  = 2'h2,
        LCDC_MUX_4  = 2'h3
    } lcdc_mux_t;

    typedef enum {
        LCDC_ST_CLEAR,
        LCDC_ST_IDLE,
        LCDC_ST_READ
    } lcdc_state_t;

endpackage

/* src/lcdc_tick_div.sv */
// Enable pulse divider: one output pulse per divisor input pulses
`timescale 1ns/1ps
module lcdc_tick_div #(
    parameter int W = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] divisor,
    output logic              tick_out
);
    logic [W-1:0] count_reg;

    // A divisor that shrinks below the count wraps at once, no long stall
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_reg <= '0;
            tick_out  <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (count_reg >= divisor - W'(1)) begin
                    count_reg <= '0;
                    tick_out  <= 1'b1;
                end else begin
                    count_reg <= count_reg + W'(1);
                end
            end
        end
    end
endmodule // lcdc_tick_div

/* src/lcdc_seg_mem.sv */
// Segment data memory with registered read data
`timescale 1ns/1ps
module lcdc_seg_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6,
    parameter int DW    = 8
) (
    input  wire logic          sys_clk,
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wr_data,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rd_en) begin
            rd_data <= mem[addr];
        end
    end
endmodule // lcdc_seg_mem

/* src/lcdc_core.sv */
// Segment display configuration, pin function and screen memory access
`timescale 1ns/1ps
`include "lcdc_cfg.svh"
module lcdc_core import lcdc_pkg::*; #(
    parameter int PRESCALE = `LCDC_PRESCALE
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    output logic             src_tick,
    output logic             waveform_tick,
    output logic             frame_tick,
    output logic      [3:0]  waveform_divisor,
    output logic      [25:0] seg_function_en,
    output logic             common_line_2_en,
    output logic             common_line_3_en,
    output logic             bias_sel,
    output logic      [1:0]  multiplex_level,
    output logic             memory_busy
);
    // -----------------------------------------------------------
    // Registers
    // -----------------------------------------------------------
    logic [7:0]  display_config_reg;
    logic [7:0]  display_clock_reg;
    logic [5:0]  seg_enable_a_reg;
    logic [3:0]  seg_enable_b_reg;
    logic        ptr_dir_reg;
    logic [1:0]  target_screen_select_reg;
    logic [3:0]  ptr_addr_reg;
    logic [7:0]  memory_byte_value_reg;
    logic        access_pending_reg;
    logic        clear_running_reg;
    logic [5:0]  clear_addr_reg;
    lcdc_state_t state_reg;

    logic        wr_hit;
    logic        ptr_write;
    logic        data_write;
    logic        cfg_write;
    logic        clear_req;
    logic        mem_wr;
    logic        mem_rd;
    logic [5:0]  mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic        addr_valid;
    logic        start_access;
    logic [3:0]  frame_divisor;
    logic [2:0]  frame_div_small;
    lcdc_mux_t   mux_mode;
    logic [3:0]  fd_code;

    assign wr_hit     = sfr_wr;
    assign ptr_write  = wr_hit && (sfr_addr == `LCDC_ADDR_POINTER);
    assign data_write = wr_hit && (sfr_addr == `LCDC_ADDR_DATA);
    assign cfg_write  = wr_hit && (sfr_addr == `LCDC_ADDR_CONFIG);
    assign clear_req  = cfg_write && sfr_wdata[`LCDC_CFG_CLEAR_BIT];
    assign mux_mode   = lcdc_mux_t'(display_config_reg[`LCDC_CFG_MUX_MSB:`LCDC_CFG_MUX_LSB]);
    assign fd_code    = display_clock_reg[`LCDC_CLK_FD_MSB:`LCDC_CLK_FD_LSB];

    // -----------------------------------------------------------
    // Configuration and clock registers
    // -----------------------------------------------------------
    // Bias and mux are taken as written; matching them to the glass is software's job
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            display_config_reg <= `LCDC_RST_BYTE;
        end else begin
            if (cfg_write) begin
                display_config_reg <= sfr_wdata;
            end else if (state_reg == LCDC_ST_CLEAR && clear_addr_reg == 6'h3f) begin
                display_config_reg[`LCDC_CFG_CLEAR_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            display_clock_reg <= `LCDC_RST_BYTE;
        end else if (wr_hit && sfr_addr == `LCDC_ADDR_CLOCK) begin
            display_clock_reg <= sfr_wdata;
        end
    end

    // -----------------------------------------------------------
    // Segment pin enables
    // -----------------------------------------------------------
    // Reserved bits are not stored, so they read back as zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            seg_enable_a_reg <= `LCDC_RST_SEGA;
        end else if (wr_hit && sfr_addr == `LCDC_ADDR_SEG_EN_A) begin
            seg_enable_a_reg <= sfr_wdata[`LCDC_SEGA_MSB:`LCDC_SEGA_LSB];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            seg_enable_b_reg <= `LCDC_RST_SEGB;
        end else if (wr_hit && sfr_addr == `LCDC_ADDR_SEG_EN_B) begin
            seg_enable_b_reg <= sfr_wdata[`LCDC_SEGB_MSB:`LCDC_SEGB_LSB];
        end
    end

    // Each bit drives exactly one pin, so any subset works and others keep GPIO
    assign seg_function_en = {seg_enable_a_reg, seg_enable_b_reg, `LCDC_FIXED_SEGS};

    // -----------------------------------------------------------
    // Shared common/segment pins
    // -----------------------------------------------------------
    always_comb begin
        common_line_2_en = 1'b0;
        common_line_3_en = 1'b0;
        case (mux_mode)
            LCDC_MUX_3: begin
                common_line_2_en = 1'b1;
            end
            LCDC_MUX_4: begin
                common_line_2_en = 1'b1;
                common_line_3_en = 1'b1;
            end
            default: begin
                common_line_2_en = 1'b0;
                common_line_3_en = 1'b0;
            end
        endcase
    end

    assign bias_sel        = display_config_reg[`LCDC_CFG_BIAS_BIT];
    assign multiplex_level = display_config_reg[`LCDC_CFG_MUX_MSB:`LCDC_CFG_MUX_LSB];

    // -----------------------------------------------------------
    // Pointer and data registers
    // -----------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ptr_dir_reg              <= 1'b0;
            target_screen_select_reg <= 2'h0;
            ptr_addr_reg             <= 4'h0;
        end else if (ptr_write) begin
            ptr_dir_reg              <= sfr_wdata[`LCDC_PTR_DIR_BIT];
            target_screen_select_reg <= sfr_wdata[`LCDC_PTR_SCR_MSB:`LCDC_PTR_SCR_LSB];
            ptr_addr_reg             <= sfr_wdata[`LCDC_PTR_ADR_MSB:`LCDC_PTR_ADR_LSB];
        end
    end

    // A software write to the data register wins over a landing read byte
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            memory_byte_value_reg <= `LCDC_RST_BYTE;
        end else if (data_write) begin
            memory_byte_value_reg <= sfr_wdata;
        end else if (state_reg == LCDC_ST_READ) begin
            memory_byte_value_reg <= addr_valid ? mem_rdata : `LCDC_RST_BYTE;
        end
    end

    // A pointer write always queues its access; a new one replaces an old one
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            access_pending_reg <= 1'b0;
        end else if (ptr_write) begin
            access_pending_reg <= 1'b1;
        end else if (start_access) begin
            access_pending_reg <= 1'b0;
        end
    end

    // -----------------------------------------------------------
    // Memory sequencer
    // -----------------------------------------------------------
    // Reset enters the sweep, so the memory is zero before first use
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg      <= LCDC_ST_CLEAR;
            clear_addr_reg <= 6'h00;
        end else begin
            case (state_reg)
                LCDC_ST_CLEAR: begin
                    clear_addr_reg <= clear_addr_reg + 6'h01;
                    if (clear_addr_reg == 6'h3f) begin
                        state_reg <= LCDC_ST_IDLE;
                    end
                end
                LCDC_ST_IDLE: begin
                    if (clear_req) begin
                        state_reg      <= LCDC_ST_CLEAR;
                        clear_addr_reg <= 6'h00;
                    end else if (start_access && !ptr_dir_reg) begin
                        state_reg <= LCDC_ST_READ;
                    end
                end
                LCDC_ST_READ: begin
                    state_reg <= clear_req ? LCDC_ST_CLEAR : LCDC_ST_IDLE;
                end
                default: begin
                    state_reg <= LCDC_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clear_running_reg <= 1'b1;
        end else begin
            clear_running_reg <= (state_reg == LCDC_ST_CLEAR) && (clear_addr_reg != 6'h3f);
        end
    end

    // Held off during the sweep and while a clear request arrives
    assign start_access = access_pending_reg && !ptr_write && !clear_req
                          && (state_reg == LCDC_ST_IDLE);
    // Byte 15 of each screen does not exist: writes dropped, reads give zero
    assign addr_valid   = (ptr_addr_reg <= `LCDC_LAST_BYTE);

    always_comb begin
        mem_wr    = 1'b0;
        mem_rd    = 1'b0;
        mem_addr  = {target_screen_select_reg, ptr_addr_reg};
        mem_wdata = memory_byte_value_reg;
        if (state_reg == LCDC_ST_CLEAR) begin
            mem_wr    = 1'b1;
            mem_addr  = clear_addr_reg;
            mem_wdata = `LCDC_RST_BYTE;
        end else if (start_access) begin
            mem_wr = ptr_dir_reg && addr_valid;
            mem_rd = !ptr_dir_reg;
        end
    end

    lcdc_seg_mem #(
        .DEPTH (64),
        .AW    (6),
        .DW    (8)
    ) u_mem (
        .sys_clk (sys_clk),
        .wr_en   (mem_wr),
        .rd_en   (mem_rd),
        .addr    (mem_addr),
        .wr_data (mem_wdata),
        .rd_data (mem_rdata)
    );

    assign memory_busy = clear_running_reg || access_pending_reg
                         || (state_reg != LCDC_ST_IDLE);

    // -----------------------------------------------------------
    // Register read
    // -----------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `LCDC_ADDR_CONFIG:   sfr_rdata <= display_config_reg;
                `LCDC_ADDR_CLOCK:    sfr_rdata <= display_clock_reg;
                `LCDC_ADDR_SEG_EN_A: sfr_rdata <= {seg_enable_a_reg, 2'h0};
                `LCDC_ADDR_SEG_EN_B: sfr_rdata <= {4'h0, seg_enable_b_reg};
                `LCDC_ADDR_POINTER:  sfr_rdata <= {ptr_dir_reg, 1'b0,
                                                   target_screen_select_reg, ptr_addr_reg};
                `LCDC_ADDR_DATA:     sfr_rdata <= memory_byte_value_reg;
                default:             sfr_rdata <= 8'h00;
            endcase
        end
    end

    // -----------------------------------------------------------
    // Slow display clock and waveform rates
    // -----------------------------------------------------------
    // Slow source clock only; no fast table
    always_comb begin
        waveform_divisor = `LCDC_DIV_8;
        if (fd_code == `LCDC_FD_FASTEST) begin
            waveform_divisor = `LCDC_DIV_1;
        end else if (fd_code == `LCDC_FD_DEFAULT) begin
            waveform_divisor = `LCDC_DIV_2;
        end else if (mux_mode == LCDC_MUX_3 || mux_mode == LCDC_MUX_4) begin
            waveform_divisor = `LCDC_DIV_4;
        end else if (fd_code == `LCDC_FD_FIRST) begin
            waveform_divisor = `LCDC_DIV_4;
        end else if (fd_code == `LCDC_FD_SECOND) begin
            waveform_divisor = `LCDC_DIV_6;
        end else begin
            waveform_divisor = `LCDC_DIV_8;
        end
    end

    // Frame spans one waveform period per common line in use
    always_comb begin
        case (mux_mode)
            LCDC_MUX_3: frame_divisor = 4'h3;
            LCDC_MUX_4: frame_divisor = 4'h4;
            default:    frame_divisor = 4'h2;
        endcase
    end
    assign frame_div_small = frame_divisor[2:0];

    lcdc_tick_div #(
        .W (19)
    ) u_src_div (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .tick_in  (1'b1),
        .divisor  (19'(PRESCALE)),
        .tick_out (src_tick)
    );

    lcdc_tick_div #(
        .W (4)
    ) u_wave_div (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .tick_in  (src_tick && display_config_reg[`LCDC_CFG_CLKSEL_BIT]),
        .divisor  (waveform_divisor),
        .tick_out (waveform_tick)
    );

    lcdc_tick_div #(
        .W (3)
    ) u_frame_div (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .tick_in  (waveform_tick),
        .divisor  (frame_div_small),
        .tick_out (frame_tick)
    );
endmodule // lcdc_core

/* test/lcdc_props.sv */
// Port checks of the display configuration and memory block
`timescale 1ns/1ps
`include "lcdc_cfg.svh"
module lcdc_props (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        src_tick,
    input wire logic        waveform_tick,
    input wire logic        frame_tick,
    input wire logic [3:0]  waveform_divisor,
    input wire logic [25:0] seg_function_en,
    input wire logic        common_line_2_en,
    input wire logic        common_line_3_en,
    input wire logic        bias_sel,
    input wire logic [1:0]  multiplex_level,
    input wire logic        memory_busy
);
    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_fixed_segs;
        seg_function_en[15:0] == `LCDC_FIXED_SEGS;
    endproperty
    a_fixed_segs: assert property (p_fixed_segs) else $error("low pins left segment mode");
    property p_common_line_2;
        common_line_2_en == multiplex_level[1];
    endproperty
    a_common_line_2: assert property (p_common_line_2) else $error("common 2 mismatch");
    property p_common_line_3;
        common_line_3_en == (multiplex_level == 2'h3);
    endproperty
    a_common_line_3: assert property (p_common_line_3) else $error("common 3 mismatch");
    property p_seg_a;
        sfr_wr && sfr_addr == `LCDC_ADDR_SEG_EN_A
            |=> seg_function_en[25:20] == $past(sfr_wdata[7:2]);
    endproperty
    a_seg_a: assert property (p_seg_a) else $error("enable A not applied");
    property p_seg_b;
        sfr_wr && sfr_addr == `LCDC_ADDR_SEG_EN_B
            |=> seg_function_en[19:16] == $past(sfr_wdata[3:0]);
    endproperty
    a_seg_b: assert property (p_seg_b) else $error("enable B not applied");
    property p_rsv_a;
        sfr_rd && sfr_addr == `LCDC_ADDR_SEG_EN_A |=> sfr_rdata[1:0] == 2'h0;
    endproperty
    a_rsv_a: assert property (p_rsv_a) else $error("reserved enable bits set");
    property p_rsv_ptr;
        sfr_rd && sfr_addr == `LCDC_ADDR_POINTER |=> !sfr_rdata[6];
    endproperty
    a_rsv_ptr: assert property (p_rsv_ptr) else $error("reserved pointer bit set");
    property p_after_reset;
        $fell(reset) |-> sfr_rdata == 8'h00 && memory_busy
            && seg_function_en == 26'h000ffff && multiplex_level == 2'h0;
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("bad state after reset");
    property p_clear_run;
        sfr_wr && sfr_addr == `LCDC_ADDR_CONFIG && sfr_wdata[6] |=> memory_busy [*8];
    endproperty
    a_clear_run: assert property (p_clear_run) else $error("clear sweep too short");
    property p_ptr_busy;
        sfr_wr && sfr_addr == `LCDC_ADDR_POINTER |=> memory_busy;
    endproperty
    a_ptr_busy: assert property (p_ptr_busy) else $error("pointer write not taken");
    property p_busy_ends;
        $rose(memory_busy) |-> ##[1:80] !memory_busy;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("memory stays busy");
    property p_cfg;
        sfr_wr && sfr_addr == `LCDC_ADDR_CONFIG |=> multiplex_level == $past(sfr_wdata[1:0])
            && bias_sel == $past(sfr_wdata[2]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config fields not stored");

    c_ptr: cover property (sfr_wr && sfr_addr == `LCDC_ADDR_POINTER);
    c_mux4: cover property (common_line_3_en && frame_tick);
    c_clear: cover property (sfr_wr && sfr_addr == `LCDC_ADDR_CONFIG && sfr_wdata[6]);
endmodule // lcdc_props

bind lcdc_core lcdc_props i_props (.*);

/* test/lcdc_glass.sv */
// Glass-side model measuring common switching and frame pacing
`timescale 1ns/1ps
module lcdc_glass (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        waveform_tick,
    input  wire logic        frame_tick,
    output logic      [15:0] wf_gap,
    output logic      [15:0] wf_per_frame,
    output logic      [15:0] frames
);
    // ------------------------------------------------
    // Pacing
    // ------------------------------------------------
    logic [15:0] gap_cnt;
    logic [15:0] wf_cnt;
    // The first figures after a rate change span two settings; read late
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gap_cnt <= 16'h0000;
            wf_gap <= 16'h0000;
        end else if (waveform_tick) begin
            wf_gap <= gap_cnt;
            gap_cnt <= 16'h0001;
        end else begin
            gap_cnt <= gap_cnt + 16'h0001;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wf_cnt <= 16'h0000;
            wf_per_frame <= 16'h0000;
            frames <= 16'h0000;
        end else if (frame_tick) begin
            wf_per_frame <= wf_cnt + {15'h0000, waveform_tick};
            wf_cnt <= 16'h0000;
            frames <= frames + 16'h0001;
        end else begin
            wf_cnt <= wf_cnt + {15'h0000, waveform_tick};
        end
    end
endmodule // lcdc_glass

/* test/lcd_driver_config_and_memory_bench.sv */
// Self-checking bench of the display configuration and memory block
`timescale 1ns/1ps
module lcd_driver_config_and_memory_bench;
    localparam int PRESCALE = 4;
    logic        sys_clk;
    logic        reset;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_rdata;
    logic        src_tick;
    logic        waveform_tick;
    logic        frame_tick;
    logic [3:0]  waveform_divisor;
    logic [25:0] seg_function_en;
    logic        common_line_2_en;
    logic        common_line_3_en;
    logic        bias_sel;
    logic [1:0]  multiplex_level;
    logic        memory_busy;
    logic [15:0] wf_gap;
    logic [15:0] wf_per_frame;
    logic [15:0] frames;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    lcdc_core #(.PRESCALE(PRESCALE)) i_dut (.*);
    lcdc_glass i_glass (.*);

    // ------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------
    task automatic check(input string n, input logic [25:0] e, input logic [25:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #2;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge sys_clk) #2;
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk) #2;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge sys_clk) #2;
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 200 && memory_busy !== 1'b0; i++) @(posedge sys_clk) #2;
        check("memory_busy", 26'h0, memory_busy);
    endtask
    task automatic mem_rd(input logic [7:0] p, output logic [7:0] d);
        wr(8'hac, p);
        wait_idle();
        rd(8'hae, d);
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_reset_values;
        logic [7:0] d;
        logic [7:0] regs [6] = '{8'h95, 8'h96, 8'h97, 8'hac, 8'hae, 8'hed};
        foreach (regs[i]) begin
            rd(regs[i], d);
            check("reg after reset", 26'h0, d);
        end
        check("seg_function_en", 26'h000ffff, seg_function_en);
        check("commons", 26'h0, {common_line_3_en, common_line_2_en});
        rd(8'h33, d);
        check("unmapped", 26'h0, d);
    endtask
    task automatic t_seg_enable;
        logic [7:0] d;
        wr(8'h97, 8'hff);
        rd(8'h97, d);
        check("enable a", 26'hfc, d);
        check("seg_function_en", 26'h3f0ffff, seg_function_en);
        wr(8'hed, 8'hff);
        rd(8'hed, d);
        check("enable b", 26'h0f, d);
        wr(8'h97, 8'h54);
        check("seg_function_en", 26'h15fffff, seg_function_en);
        wr(8'hed, 8'h05);
        check("seg_function_en", 26'h155ffff, seg_function_en);
    endtask
    task automatic t_mux;
        logic [7:0] d;
        for (int m = 0; m < 4; m++) begin
            wr(8'h95, 8'h04 | m[7:0]);
            check("common 2", m >= 2, common_line_2_en);
            check("common 3", m == 3, common_line_3_en);
            rd(8'h95, d);
            check("config", 8'h04 | m[7:0], d);
        end
    endtask
    task automatic t_memory;
        logic [7:0] d;
        wait_idle();
        for (int s = 0; s < 4; s++) begin
            wr(8'hae, 8'h19 + 8'h22 * s[7:0]);
            wr(8'hac, {2'b10, s[1:0], 4'he});
            wait_idle();
        end
        for (int s = 3; s >= 0; s--) begin
            mem_rd({2'b00, s[1:0], 4'he}, d);
            check("screen byte", 8'h19 + 8'h22 * s[7:0], d);
        end
        rd(8'hac, d);
        check("pointer", 26'h0e, d);
        mem_rd(8'h0f, d);
        check("byte 15", 26'h0, d);
        wr(8'hae, 8'ha5);
        rd(8'hae, d);
        check("data reg", 26'ha5, d);
    endtask
    task automatic t_clear;
        logic [7:0] d;
        wr(8'hae, 8'h77);
        wr(8'hac, 8'ha5);
        wait_idle();
        wr(8'h95, 8'h40);
        wr(8'hac, 8'h25);
        rd(8'h95, d);
        check("clear bit", 26'h40, d);
        wait_idle();
        rd(8'hae, d);
        check("cleared byte", 26'h0, d);
        rd(8'h95, d);
        check("clear bit", 26'h0, d);
    endtask
    task automatic t_por;
        logic [7:0] d;
        wr(8'hae, 8'hc3);
        wr(8'hac, 8'hb1);
        wait_idle();
        reset = 1'b1;
        repeat (2) @(posedge sys_clk);
        #2 reset = 1'b0;
        mem_rd(8'h31, d);
        check("byte after reset", 26'h0, d);
    endtask
    task automatic t_rates;
        logic [11:0] cases [10] = '{12'h014, 12'h026, 12'h058, 12'h0f1, 12'h002,
                                    12'h214, 12'h2e4, 12'h374, 12'h3f1, 12'h202};
        logic [1:0]  m;
        logic [3:0]  fd;
        logic [3:0]  dv;
        logic [15:0] f0;
        foreach (cases[i]) begin
            {m, fd, dv} = cases[i][9:0];
            wr(8'h95, {6'h02, m});
            wr(8'h96, {4'h0, fd});
            check("divisor", dv, waveform_divisor);
            f0 = frames;
            for (int k = 0; k < 1000 && frames < f0 + 16'h0003; k++) @(posedge sys_clk) #2;
            check("waveform gap", dv * PRESCALE, wf_gap);
            check("ticks per frame", (m < 2'h2) ? 2 : m + 1, wf_per_frame);
        end
    endtask

    // ------------------------------------------------
    // Run control
    // ------------------------------------------------
    task automatic test_done;
        if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Run needs about 1500 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        reset = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        repeat (12) @(posedge sys_clk);
        #2 reset = 1'b0;
        t_reset_values();
        t_seg_enable();
        t_mux();
        t_memory();
        t_clear();
        t_por();
        t_rates();
        test_done();
    end
endmodule // lcd_driver_config_and_memory_bench
